// ===== design/icc_chunk_framer.sv
// Purpose: Frame and trigger tallies with metadata chunks and CRC-16
// Assumes: Events are one-cycle pulses on i_mclk; input_pin_one is async
// Notes:   Payload passes at most one beat every two cycles
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps

module icc_chunk_framer
  import icc_pkg::*;
#(
  parameter int unsigned TALLY_W = CNT_WIDTH
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  // Acquisition events
  input  wire logic        i_exposure_begin_event,
  input  wire logic        i_external_acq_trigger_event,
  input  wire logic        i_input_pin_one,
  // Image payload in
  input  wire icc_beat_t   i_img,
  input  wire logic        i_img_valid,
  output logic             o_img_ready,
  // Image with chunks out
  output icc_beat_t        o_out,
  output logic             o_out_valid,
  input  wire logic        i_out_ready
);

  // Narrower tallies let a test reach the wrap without billions of events
  if (TALLY_W < 1 || TALLY_W > CNT_WIDTH) begin : g_width_check
    $error("TALLY_W must lie between 1 and CNT_WIDTH");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration state

  logic                metadata_append_global_on_reg;
  logic [1:0]          metadata_item_select_reg;
  logic                trig_item_on_reg;
  logic                crc_item_on_reg;
  logic [1:0]          tally_slot_select_reg;
  logic [1:0]          tally_clear_source_reg [2];
  logic                trig_function_on_reg;
  logic [15:0]         last_crc_reg;
  logic [TALLY_W-1:0]  tally_reg [2];
  logic [31:0]         tally_word [2];

  logic        bus_req;
  logic        wr_take;
  logic        slot_idx;
  logic [1:0]  soft_clear;

  assign bus_req  = i_read | i_write;
  assign wr_take  = i_write & ~o_waitrequest;
  assign slot_idx = (tally_slot_select_reg == FRAME_TALLY_SLOT);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the answer
  // Read data loads in the wait cycle so it stands at the accepting edge

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= ~(bus_req & o_waitrequest);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_readdata <= ZERO_WORD;
    end else if (i_read & o_waitrequest) begin
      unique case (i_address)
        OFS_GLOBAL:   o_readdata <= {31'h0, metadata_append_global_on_reg};
        OFS_ITEM_SEL: o_readdata <= {30'h0, metadata_item_select_reg};
        OFS_ITEM_ON:  o_readdata <= {31'h0,
          (metadata_item_select_reg == ITEM_TRIG) ? trig_item_on_reg :
          (metadata_item_select_reg == ITEM_CRC)  ? crc_item_on_reg : 1'b0};
        OFS_SLOT_SEL: o_readdata <= {30'h0, tally_slot_select_reg};
        OFS_INC_SRC:  o_readdata <= {30'h0, slot_idx ?
                        SRC_EXPOSURE_BEGIN : SRC_EXT_ACQ_TRIGGER};
        OFS_CLR_SRC:  o_readdata <= {30'h0, tally_clear_source_reg[slot_idx]};
        OFS_TALLY:    o_readdata <= (!slot_idx && !trig_function_on_reg) ?
                        ZERO_WORD : tally_word[slot_idx];
        OFS_TRIG_FN:  o_readdata <= {31'h0, trig_function_on_reg};
        OFS_LAST_CRC: o_readdata <= {16'h0, last_crc_reg};
        default:      o_readdata <= ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      metadata_append_global_on_reg <= 1'b0;
      metadata_item_select_reg      <= ITEM_TRIG;
      trig_item_on_reg              <= 1'b0;
      crc_item_on_reg               <= 1'b0;
      tally_slot_select_reg         <= TRIG_TALLY_SLOT;
      trig_function_on_reg          <= 1'b0;
      tally_clear_source_reg[0]     <= CLR_OFF;
      tally_clear_source_reg[1]     <= CLR_OFF;
    end else if (wr_take) begin
      unique case (i_address)
        OFS_GLOBAL: begin
          metadata_append_global_on_reg <= i_writedata[0];
          if (!i_writedata[0]) begin
            trig_item_on_reg <= 1'b0;
            crc_item_on_reg  <= 1'b0;
          end
        end
        OFS_ITEM_SEL: metadata_item_select_reg <= i_writedata[1:0];
        OFS_ITEM_ON: begin
          // Writes are dropped while global mode is off
          if (metadata_append_global_on_reg) begin
            if (metadata_item_select_reg == ITEM_TRIG) begin
              trig_item_on_reg <= i_writedata[0];
            end
            if (metadata_item_select_reg == ITEM_CRC) begin
              crc_item_on_reg <= i_writedata[0];
            end
          end
        end
        // Selector values outside the two slots are ignored
        OFS_SLOT_SEL: begin
          if (i_writedata[1:0] == TRIG_TALLY_SLOT ||
              i_writedata[1:0] == FRAME_TALLY_SLOT) begin
            tally_slot_select_reg <= i_writedata[1:0];
          end
        end
        OFS_CLR_SRC: begin
          if (i_writedata[1:0] != 2'h3) begin
            tally_clear_source_reg[slot_idx] <= i_writedata[1:0];
          end
        end
        OFS_TRIG_FN: trig_function_on_reg <= i_writedata[0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin one synchroniser and edge detect
  // The first flop feeds only the second; the third holds the second's previous level for the edge detect

  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;
  logic pin_rise;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= i_input_pin_one;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign pin_rise = pin_sync_reg & ~pin_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Tallies: index 0 is the trigger slot, index 1 the frame slot

  logic [1:0] tally_inc;

  assign tally_inc[0] = i_external_acq_trigger_event &
                        trig_function_on_reg;
  assign tally_inc[1] = i_exposure_begin_event;

  for (genvar k = 0; k < 2; k++) begin : g_tally
    logic clear;
    // Narrow tallies are read back and snapshot as zero-extended words
    assign tally_word[k] = 32'(tally_reg[k]);
    assign soft_clear[k] = wr_take && (i_address == OFS_CLR_CMD) &&
                           (slot_idx == k) &&
                           (tally_clear_source_reg[k] == CLR_SOFT);
    // Clear beats a same-cycle increment
    assign clear = soft_clear[k] ||
                   (pin_rise &&
                    tally_clear_source_reg[k] == CLR_PIN_ONE);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        tally_reg[k] <= '0;
      end else if (clear) begin
        tally_reg[k] <= '0;
      end else if (tally_inc[k]) begin
        // Natural wrap to zero after the maximum
        tally_reg[k] <= tally_reg[k] + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chunk framer

  function automatic logic [15:0] crc_word(input logic [15:0] crc,
                                           input logic [31:0] d);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int b = 31; b >= 0; b--) begin
      fb = c[15] ^ d[b];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  icc_state_t  state_reg;
  icc_state_t  state_next;
  logic [31:0] img_bytes_reg;
  logic [15:0] crc_reg;
  logic [31:0] trig_snap_reg;
  logic        add_trig_reg;
  logic        add_crc_reg;
  logic        take_in;
  logic        emit;
  logic        out_free;
  logic        valid_next;
  icc_beat_t   beat;

  assign out_free = ~o_out_valid | i_out_ready;
  assign take_in  = o_img_ready & i_img_valid;
  assign emit     = (state_reg != ST_PAYLOAD) & out_free;

  always_comb begin
    beat       = '{data: ZERO_WORD, last: 1'b0};
    state_next = state_reg;
    if (take_in) begin
      beat.data = i_img.data;
      beat.last = i_img.last & ~metadata_append_global_on_reg;
      if (i_img.last && metadata_append_global_on_reg) begin
        state_next = ST_IMG_ID;
      end
    end else if (emit) begin
      unique case (state_reg)
        ST_IMG_ID: begin
          beat.data  = ID_IMAGE;
          state_next = ST_IMG_LEN;
        end
        ST_IMG_LEN: begin
          beat.data  = img_bytes_reg;
          beat.last  = ~add_trig_reg & ~add_crc_reg;
          state_next = add_trig_reg ? ST_TRG_VAL :
                       add_crc_reg  ? ST_CRC_VAL : ST_PAYLOAD;
        end
        ST_TRG_VAL: begin
          beat.data  = trig_snap_reg;
          state_next = ST_TRG_ID;
        end
        ST_TRG_ID: begin
          beat.data  = ID_TRIG;
          state_next = ST_TRG_LEN;
        end
        ST_TRG_LEN: begin
          beat.data  = LEN_WORD_CHUNK;
          beat.last  = ~add_crc_reg;
          state_next = add_crc_reg ? ST_CRC_VAL : ST_PAYLOAD;
        end
        ST_CRC_VAL: begin
          beat.data  = {16'h0000, crc_reg};
          state_next = ST_CRC_ID;
        end
        ST_CRC_ID: begin
          beat.data  = ID_CRC;
          state_next = ST_CRC_LEN;
        end
        ST_CRC_LEN: begin
          beat.data  = LEN_WORD_CHUNK;
          beat.last  = 1'b1;
          state_next = ST_PAYLOAD;
        end
        default: ;
      endcase
    end
  end

  assign valid_next = take_in | emit | (o_out_valid & ~i_out_ready);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= ST_PAYLOAD;
      o_out_valid <= 1'b0;
      o_out       <= '{data: ZERO_WORD, last: 1'b0};
      o_img_ready <= 1'b0;
    end else begin
      state_reg   <= state_next;
      o_out_valid <= valid_next;
      if (take_in | emit) begin
        o_out <= beat;
      end
      // Ready only when the output stage will be empty; halves throughput
      // but keeps every output straight from a flip-flop
      o_img_ready <= (state_next == ST_PAYLOAD) & ~valid_next;
    end
  end

  // Trailer contents fixed at the end of the payload
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      add_trig_reg  <= 1'b0;
      add_crc_reg   <= 1'b0;
      trig_snap_reg <= ZERO_WORD;
    end else if (take_in && i_img.last) begin
      add_trig_reg  <= metadata_append_global_on_reg & trig_item_on_reg &
                       trig_function_on_reg;
      add_crc_reg   <= metadata_append_global_on_reg &
                       crc_item_on_reg;
      trig_snap_reg <= tally_word[0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      img_bytes_reg <= ZERO_WORD;
    end else if (emit && state_reg == ST_IMG_LEN) begin
      img_bytes_reg <= ZERO_WORD;
    end else if (take_in) begin
      img_bytes_reg <= img_bytes_reg + BYTES_PER_BEAT;
    end
  end

  // Every word ahead of the checksum word is folded in
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crc_reg      <= CRC_INIT;
      last_crc_reg <= CRC_INIT;
    end else if ((take_in | emit) && beat.last) begin
      crc_reg <= CRC_INIT;
    end else if (emit && state_reg == ST_CRC_VAL) begin
      last_crc_reg <= crc_reg;
    end else if (take_in | (emit & (state_reg != ST_CRC_ID))) begin
      crc_reg <= crc_word(crc_reg, beat.data);
    end
  end

endmodule

// ===== design/icc_pkg.sv
// Purpose: Shared constants and types for the image chunk framer
// Assumes: 32-bit register and stream words
// Notes:   Chunk identifiers are arbitrary values
package icc_pkg;

  localparam int unsigned CNT_WIDTH = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_GLOBAL    = 8'h00;
  localparam logic [7:0] OFS_ITEM_SEL  = 8'h04;
  localparam logic [7:0] OFS_ITEM_ON   = 8'h08;
  localparam logic [7:0] OFS_SLOT_SEL  = 8'h0C;
  localparam logic [7:0] OFS_INC_SRC   = 8'h10;
  localparam logic [7:0] OFS_CLR_SRC   = 8'h14;
  localparam logic [7:0] OFS_CLR_CMD   = 8'h18;
  localparam logic [7:0] OFS_TALLY     = 8'h1C;
  localparam logic [7:0] OFS_TRIG_FN   = 8'h20;
  localparam logic [7:0] OFS_LAST_CRC  = 8'h24;

  // Item selector codes
  localparam logic [1:0] ITEM_TRIG = 2'h0;
  localparam logic [1:0] ITEM_CRC  = 2'h1;

  // Tally slot codes
  localparam logic [1:0] TRIG_TALLY_SLOT  = 2'h1;
  localparam logic [1:0] FRAME_TALLY_SLOT = 2'h2;

  // Increment source codes
  localparam logic [1:0] SRC_EXT_ACQ_TRIGGER = 2'h1;
  localparam logic [1:0] SRC_EXPOSURE_BEGIN  = 2'h2;

  // Clear source codes
  localparam logic [1:0] CLR_OFF     = 2'h0;
  localparam logic [1:0] CLR_PIN_ONE = 2'h1;
  localparam logic [1:0] CLR_SOFT    = 2'h2;

  // Chunk identifiers, arbitrary values
  localparam logic [31:0] ID_IMAGE = 32'hC0DE0001;
  localparam logic [31:0] ID_TRIG  = 32'hC0DE0002;
  localparam logic [31:0] ID_CRC   = 32'hC0DE0003;

  localparam logic [31:0] LEN_WORD_CHUNK = 32'h00000004;
  localparam logic [31:0] BYTES_PER_BEAT = 32'h00000004;
  localparam logic [31:0] ZERO_WORD      = 32'h00000000;

  // CRC-16 X-modem
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } icc_beat_t;

  typedef enum logic [3:0] {
    ST_PAYLOAD,
    ST_IMG_ID,
    ST_IMG_LEN,
    ST_TRG_VAL,
    ST_TRG_ID,
    ST_TRG_LEN,
    ST_CRC_VAL,
    ST_CRC_ID,
    ST_CRC_LEN
  } icc_state_t;

endpackage

// ===== dv/icc_chunk_framer_assertions.sv
// Purpose: Port-level checks for the chunk framer
// Assumes: Single clock domain, async active-low reset
// Notes:   Payload must never carry chunk identifier values
`timescale 1ns/100ps

module icc_chunk_framer_assertions
  import icc_pkg::*;
#(
  parameter int unsigned TALLY_W = CNT_WIDTH
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [31:0] o_readdata,
  input  wire logic        o_waitrequest,
  input  wire logic        i_exposure_begin_event,
  input  wire logic        i_external_acq_trigger_event,
  input  wire logic        i_input_pin_one,
  input  wire icc_beat_t   i_img,
  input  wire logic        i_img_valid,
  input  wire logic        o_img_ready,
  input  wire icc_beat_t   o_out,
  input  wire logic        o_out_valid,
  input  wire logic        i_out_ready
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  logic hs;
  assign hs = o_out_valid && i_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  AST_BUS_ONE_WAIT: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("bus access not answered after one wait cycle");
  AST_BUS_IDLE: assert property (
    !(i_read || i_write) |=> o_waitrequest)
    else $error("waitrequest dropped without a request");
  AST_OUT_HOLD: assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
    else $error("output beat changed while stalled");
  AST_PASS_THROUGH: assert property (
    o_img_ready && i_img_valid
    |=> o_out_valid && o_out.data == $past(i_img.data))
    else $error("payload beat not forwarded unchanged");
  AST_IN_GAP: assert property (
    o_img_ready && i_img_valid |=> !o_img_ready)
    else $error("payload accepted on consecutive cycles");
  AST_TRAILER_BLOCKS: assert property (
    o_out_valid && o_out.data == ID_IMAGE |-> !o_img_ready)
    else $error("payload accepted during trailer");
  AST_IMG_LEN: assert property (
    hs && o_out.data == ID_IMAGE
    |=> o_out_valid && o_out.data[1:0] == 2'h0 && o_out.data != ZERO_WORD)
    else $error("image length word malformed");
  AST_TRIG_LEN: assert property (
    hs && o_out.data == ID_TRIG |=> o_out_valid && o_out.data == LEN_WORD_CHUNK)
    else $error("trigger chunk length word wrong");
  AST_CRC_LAST: assert property (
    hs && o_out.data == ID_CRC
    |=> o_out_valid && o_out.data == LEN_WORD_CHUNK && o_out.last)
    else $error("checksum chunk not closing the image");
endmodule

bind icc_chunk_framer icc_chunk_framer_assertions #(.TALLY_W(TALLY_W))
  u_icc_chunk_framer_assertions (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_exposure_begin_event(i_exposure_begin_event),
  .i_external_acq_trigger_event(i_external_acq_trigger_event),
  .i_input_pin_one(i_input_pin_one), .i_img(i_img),
  .i_img_valid(i_img_valid), .o_img_ready(o_img_ready), .o_out(o_out),
  .o_out_valid(o_out_valid), .i_out_ready(i_out_ready));

// ===== dv/icc_host_model.sv
// Purpose: Host side sink that stores one image and checks its checksum
// Assumes: At most 16 words per image
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/100ps

module icc_host_model
  import icc_pkg::*;
(
  input  wire logic      i_mclk,
  input  wire logic      i_rst_n,
  input  wire icc_beat_t i_out,
  input  wire logic      i_out_valid,
  input  wire logic      i_slow,
  output logic           o_out_ready,
  output logic [31:0]    o_frames,
  output logic [4:0]     o_nw,
  output logic           o_crc_ok
);
  logic [31:0] words [0:15];
  logic        tog_reg;
  logic        fin_reg;
  logic [15:0] c;

  assign o_out_ready = !i_slow || tog_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) tog_reg <= 1'b0;
    else tog_reg <= !tog_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nw     <= 5'h0;
      fin_reg  <= 1'b1;
      o_frames <= 32'h0;
    end else if (i_out_valid && o_out_ready) begin
      o_nw    <= fin_reg ? 5'h1 : o_nw + 5'h1;
      fin_reg <= i_out.last;
      if (i_out.last) o_frames <= o_frames + 32'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_out_valid && o_out_ready) words[fin_reg ? 5'h0 : o_nw] <= i_out.data;
  end

  // Checksum word sits three from the end; ID and length follow it
  always_comb begin
    c = CRC_INIT;
    for (int i = 0; i < 16; i++)
      if (i + 3 < o_nw)
        for (int b = 31; b >= 0; b--)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ words[i][b]) ? CRC_POLY : 16'h0000);
    o_crc_ok = (o_nw > 5'h3) && (c == words[o_nw - 5'h3][15:0]);
  end
endmodule

// ===== dv/icc_chunk_framer_tb_top.sv
// Purpose: Self-checking bench for the chunk framer
// Assumes: Both tallies shortened to 4 bits so wrap is reachable
// Notes:   Register rows first, then hand-written cases
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end

module icc_chunk_framer_tb_top
  import icc_pkg::*;
;
  localparam int unsigned TW = 4;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} icc_row_t;
  logic        mclk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        wait_req, exp_ev = 1'b0, trg_ev = 1'b0, pin = 1'b0;
  icc_beat_t   img = '0, out;
  logic        img_vld = 1'b0, img_rdy, out_vld, out_rdy, slow = 1'b0;
  logic [31:0] ew [11];
  logic [15:0] c;
  int          error_cnt = 0, n_tests = 0;
  icc_row_t    rows [16] = '{
    '{1'b0, OFS_GLOBAL, 32'h0}, '{1'b0, OFS_SLOT_SEL, 32'h1},
    '{1'b0, OFS_INC_SRC, 32'h1}, '{1'b0, OFS_CLR_SRC, 32'h0},
    '{1'b0, OFS_TALLY, 32'h0}, '{1'b1, OFS_SLOT_SEL, 32'h2},
    '{1'b0, OFS_INC_SRC, 32'h2}, '{1'b0, OFS_CLR_SRC, 32'h0},
    '{1'b0, OFS_TALLY, 32'h0}, '{1'b1, OFS_SLOT_SEL, 32'h3},
    '{1'b0, OFS_SLOT_SEL, 32'h2}, '{1'b1, OFS_ITEM_ON, 32'h1},
    '{1'b1, OFS_GLOBAL, 32'h1}, '{1'b0, OFS_ITEM_ON, 32'h0},
    '{1'b1, 8'h30, 32'h5}, '{1'b0, 8'h30, 32'h0}};

  always #12.5 mclk = ~mclk;

  icc_chunk_framer #(.TALLY_W(TW)) u_icc_chunk_framer (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(wait_req), .i_exposure_begin_event(exp_ev),
    .i_external_acq_trigger_event(trg_ev), .i_input_pin_one(pin),
    .i_img(img), .i_img_valid(img_vld), .o_img_ready(img_rdy),
    .o_out(out), .o_out_valid(out_vld), .i_out_ready(out_rdy));

  icc_host_model u_icc_host_model (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_out(out), .i_out_valid(out_vld),
    .i_slow(slow), .o_out_ready(out_rdy), .o_frames(), .o_nw(), .o_crc_ok());

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    do @(posedge mclk); while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0; rd <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // Pulses are spaced two cycles so each is a clean one-cycle event
  task automatic pulse(input logic t, input int k);
    repeat (k) begin
      @(posedge mclk); trg_ev <= t; exp_ev <= !t;
      @(posedge mclk); trg_ev <= 1'b0; exp_ev <= 1'b0;
    end
  endtask
  task automatic send(input int n, input logic [31:0] base);
    logic [31:0] f;
    f = u_icc_host_model.o_frames;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk); img <= '{data: base + i, last: (i == n - 1)};
      img_vld <= 1'b1;
      do @(posedge mclk); while (img_rdy !== 1'b1);
      img_vld <= 1'b0;
    end
    while (u_icc_host_model.o_frames === f) @(posedge mclk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    error_cnt++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i])
      if (rows[i].wr) reg_wr(rows[i].a, rows[i].d);
      else chk_rd(rows[i].a, rows[i].d);
    reg_wr(OFS_SLOT_SEL, 32'h1);
    pulse(1'b1, 1); chk_rd(OFS_TALLY, 32'h0);
    reg_wr(OFS_TRIG_FN, 32'h1);
    pulse(1'b1, 1); chk_rd(OFS_TALLY, 32'h1);
    pulse(1'b1, 2); chk_rd(OFS_TALLY, 32'h3);
    reg_wr(OFS_SLOT_SEL, 32'h2);
    pulse(1'b0, 2); chk_rd(OFS_TALLY, 32'h2);
    reg_wr(OFS_CLR_SRC, 32'(CLR_SOFT));
    reg_wr(OFS_CLR_CMD, 32'h1); chk_rd(OFS_TALLY, 32'h0);
    pulse(1'b0, 1);
    reg_wr(OFS_SLOT_SEL, 32'h1);
    reg_wr(OFS_CLR_CMD, 32'h1); chk_rd(OFS_TALLY, 32'h3);
    reg_wr(OFS_CLR_SRC, 32'(CLR_PIN_ONE));
    @(posedge mclk); pin <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_rd(OFS_TALLY, 32'h0);
    pulse(1'b1, 1); chk_rd(OFS_TALLY, 32'h1);
    pin <= 1'b0;
    reg_wr(OFS_SLOT_SEL, 32'h2); chk_rd(OFS_TALLY, 32'h1);
    reg_wr(OFS_SLOT_SEL, 32'h1);
    pulse(1'b1, 15); chk_rd(OFS_TALLY, 32'((1 + 15) % (1 << TW)));
    pulse(1'b1, 1); chk_rd(OFS_TALLY, 32'h1);
    reg_wr(OFS_ITEM_SEL, 32'(ITEM_TRIG)); reg_wr(OFS_ITEM_ON, 32'h1);
    reg_wr(OFS_ITEM_SEL, 32'(ITEM_CRC)); reg_wr(OFS_ITEM_ON, 32'h1);
    slow <= 1'b1;
    send(3, 32'h11110000);
    ew = '{32'h11110000, 32'h11110001, 32'h11110002, ID_IMAGE, 32'h0000000C,
           32'h1, ID_TRIG, LEN_WORD_CHUNK, ZERO_WORD, ID_CRC, LEN_WORD_CHUNK};
    c = 16'h0000;
    for (int i = 0; i < 8; i++)
      for (int b = 31; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ ew[i][b]) ? 16'h1021 : 16'h0000);
    ew[8] = {16'h0000, c};
    `CHK(u_icc_host_model.o_nw, 5'hB)
    for (int i = 0; i < 11; i++)
      `CHK(u_icc_host_model.words[i], ew[i])
    `CHK(u_icc_host_model.o_crc_ok, 1'b1)
    chk_rd(OFS_LAST_CRC, ew[8]);
    reg_wr(OFS_GLOBAL, 32'h0);
    send(2, 32'h22220000);
    `CHK(u_icc_host_model.o_nw, 5'h2)
    `CHK(u_icc_host_model.words[1], 32'h22220001)
    reg_wr(OFS_GLOBAL, 32'h1); chk_rd(OFS_ITEM_ON, 32'h0);
    // Common start by pin one, then more triggers than frames
    reg_wr(OFS_SLOT_SEL, 32'h2);
    reg_wr(OFS_CLR_SRC, 32'(CLR_PIN_ONE));
    @(posedge mclk);
    pin <= 1'b1;
    repeat (4) @(posedge mclk);
    pulse(1'b1, 3);
    pulse(1'b0, 1);
    chk_rd(OFS_TALLY, 32'h1);
    reg_wr(OFS_SLOT_SEL, 32'h1);
    chk_rd(OFS_TALLY, 32'h3);
    end_sim();
  end
endmodule
